// ==== src/uart_rx_pkg.sv ====
// Purpose: shared types and constants of the asynchronous receive front end
// Assumes: one system clock; sample ticks come from the divisor counter
// Notes: frame and configuration travel as packed structs
package uart_rx_pkg;

  // ----------------------------------------------------------------------
  // oversampling and voting positions
  // ----------------------------------------------------------------------
  localparam logic [4:0] SAMPLES_NORMAL = 5'h10; // 16 samples per bit
  localparam logic [4:0] SAMPLES_DOUBLE = 5'h08; // 8 samples per bit
  localparam logic [4:0] FIRST_VOTE_NORMAL = 5'h08; // samples 8, 9, 10
  localparam logic [4:0] FIRST_VOTE_DOUBLE = 5'h04; // samples 4, 5, 6
  localparam logic [4:0] FIRST_SAMPLE = 5'h01; // first low sample

  // ----------------------------------------------------------------------
  // frame format limits and reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] DATA_BITS_MAX = 4'h9;
  localparam int DATA_W = 9;
  localparam logic [11:0] DIVISOR_RESET = 12'h000;
  localparam logic LINE_IDLE = 1'b1;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_START = 3'b010,
    ST_BITS = 3'b100
  } rx_state_t;

  typedef struct packed {
    logic double_speed_select;
    logic [3:0] data_bits; // 5 to 9
    logic parity_enable;
    logic address_filter_enable;
  } rx_cfg_t;

  typedef struct packed {
    logic [DATA_W-1:0] data; // ninth bit in data[8]
    logic ninth_received_bit;
    logic parity_bit;
    logic stop_bit_error_flag;
    logic address_frame;
  } rx_frame_t;

  // two-of-three vote
  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3

endpackage : uart_rx_pkg

// ==== src/rx_sync.sv ====
// Purpose: two-stage synchroniser for the serial input
// Assumes: line idles high
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module rx_sync
  import uart_rx_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic serial_in_pin,
  output logic serial_sync
);

  logic meta;
  logic next_meta;
  logic next_sync;

  // ----------------------------------------------------------------------
  // two flops into the clock domain
  // ----------------------------------------------------------------------
  always_comb begin
    next_meta = serial_in_pin;
    next_sync = meta;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= LINE_IDLE;
      serial_sync <= LINE_IDLE;
    end else begin
      meta <= next_meta;
      serial_sync <= next_sync;
    end
  end

  a_sync_two_stage: assert property (@(posedge clk) disable iff (!arst_n)
    ##2 (serial_sync == $past(serial_in_pin, 2)))
    else $error("synchroniser delay is not two cycles");

endmodule : rx_sync
`default_nettype wire

// ==== src/rx_sample_tick.sv ====
// Purpose: sample tick generator from the baud divisor
// Assumes: tick rate is clk / (baud_divisor + 1)
// Notes: tick is one clock wide
`timescale 1ns/10ps
`default_nettype none
module rx_sample_tick
  import uart_rx_pkg::*;
#(
  parameter int DIV_W = 12
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [DIV_W-1:0] baud_divisor,
  output logic sample_tick
);

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;

  // ----------------------------------------------------------------------
  // down counter, reload on zero
  // ----------------------------------------------------------------------
  always_comb begin
    if (count == '0) begin
      next_count = baud_divisor;
    end else begin
      next_count = count - {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= DIV_W'(DIVISOR_RESET);
    end else begin
      count <= next_count;
    end
  end

  assign sample_tick = (count == '0);

endmodule : rx_sample_tick
`default_nettype wire

// ==== src/uart_rx_recovery.sv ====
// Purpose: clock and data recovery of the asynchronous receiver
// Assumes: remote transmitter idles high, LSB first, one start bit
// Notes: frame_valid pulses once per accepted frame; dropped frames none
`timescale 1ns/10ps
`default_nettype none
module uart_rx_recovery
  import uart_rx_pkg::*;
#(
  parameter int DIV_W = 12
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic serial_in_pin,
  input wire logic [DIV_W-1:0] baud_divisor,
  input wire rx_cfg_t cfg,
  output rx_frame_t frame,
  output logic frame_valid,
  output logic rx_busy
);

  // ----------------------------------------------------------------------
  // line synchroniser and sample tick
  // ----------------------------------------------------------------------
  logic rx;
  logic tick;

  rx_sync u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .serial_in_pin(serial_in_pin),
    .serial_sync(rx)
  );

  rx_sample_tick #(.DIV_W(DIV_W)) u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .baud_divisor(baud_divisor),
    .sample_tick(tick)
  );

  // ----------------------------------------------------------------------
  // recovery state
  // ----------------------------------------------------------------------
  rx_state_t state;
  rx_state_t next_state;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic rx_prev;
  logic next_rx_prev;
  logic [1:0] votes;
  logic [1:0] next_votes;
  logic [3:0] bit_idx;
  logic [3:0] next_bit_idx;
  logic [DATA_W-1:0] shift;
  logic [DATA_W-1:0] next_shift;
  logic par;
  logic next_par;
  rx_frame_t next_frame;
  logic next_frame_valid;

  logic [4:0] spb;
  logic [4:0] first_vote;
  logic [4:0] last_vote;
  logic [4:0] num;
  logic [3:0] nbits;
  logic vote_bit;
  logic at_last_vote;
  logic start_reject;
  logic frame_done;
  logic frame_type;

  // mode selection and vote window
  always_comb begin
    if (cfg.double_speed_select) begin
      spb = SAMPLES_DOUBLE;
      first_vote = FIRST_VOTE_DOUBLE;
    end else begin
      spb = SAMPLES_NORMAL;
      first_vote = FIRST_VOTE_NORMAL;
    end
    last_vote = first_vote + 5'h02;
    nbits = cfg.data_bits + {3'h0, cfg.parity_enable};
  end

  // sample number of the current tick, wraps each bit period
  always_comb begin
    if (cnt >= spb) begin
      num = FIRST_SAMPLE;
    end else begin
      num = cnt + 5'h01;
    end
    vote_bit = maj3(votes[1], votes[0], rx);
    at_last_vote = tick && (num == last_vote);
    start_reject = (state == ST_START) && at_last_vote && vote_bit;
    frame_done = (state == ST_BITS) && at_last_vote && (bit_idx == nbits);
  end

  // frame type from ninth bit or first stop bit
  always_comb begin
    if (cfg.data_bits == DATA_BITS_MAX) begin
      frame_type = shift[DATA_W-1];
    end else begin
      frame_type = vote_bit;
    end
  end

  // next state of the recovery machine
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_rx_prev = rx_prev;
    next_votes = votes;
    next_bit_idx = bit_idx;
    next_shift = shift;
    next_par = par;
    next_frame = frame;
    next_frame_valid = 1'b0;
    if (tick) begin
      next_rx_prev = rx;
      case (state)
        ST_IDLE: begin
          if (rx_prev && !rx) begin
            next_state = ST_START;
            next_cnt = FIRST_SAMPLE;
          end
        end
        ST_START: begin
          next_cnt = num;
          if (num >= first_vote && num < last_vote) begin
            next_votes = {votes[0], rx};
          end
          if (num == last_vote) begin
            if (vote_bit) begin
              next_state = ST_IDLE;
            end else begin
              next_state = ST_BITS;
              next_bit_idx = 4'h0;
              next_shift = '0;
            end
          end
        end
        ST_BITS: begin
          next_cnt = num;
          if (num >= first_vote && num < last_vote) begin
            next_votes = {votes[0], rx};
          end
          if (num == last_vote) begin
            next_bit_idx = bit_idx + 4'h1;
            if (bit_idx < cfg.data_bits && bit_idx < DATA_BITS_MAX) begin
              next_shift[bit_idx] = vote_bit;
            end else if (bit_idx < nbits) begin
              next_par = vote_bit;
            end
            if (bit_idx == nbits) begin
              // stop bit: end of frame, back to edge search at once
              next_state = ST_IDLE;
              next_frame.data = shift;
              next_frame.ninth_received_bit = shift[DATA_W-1];
              next_frame.parity_bit = par;
              next_frame.stop_bit_error_flag = !vote_bit;
              next_frame.address_frame = frame_type;
              // filter gates only the receive hand-off
              next_frame_valid = !cfg.address_filter_enable
                || frame_type;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // registers of the recovery machine
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      cnt <= FIRST_SAMPLE;
      rx_prev <= LINE_IDLE;
      votes <= 2'h0;
      bit_idx <= 4'h0;
      shift <= '0;
      par <= 1'b0;
      frame <= '0;
      frame_valid <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      rx_prev <= next_rx_prev;
      votes <= next_votes;
      bit_idx <= next_bit_idx;
      shift <= next_shift;
      par <= next_par;
      frame <= next_frame;
      frame_valid <= next_frame_valid;
    end
  end

  assign rx_busy = (state != ST_IDLE);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic prev_start;
  logic [4:0] prev_num;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_start <= 1'b0;
      prev_num <= FIRST_SAMPLE;
    end else begin
      prev_start <= (state == ST_START);
      prev_num <= num;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_edge_starts: assert property (
    (state == ST_IDLE) && tick && rx_prev && !rx
      |=> (state == ST_START) && (cnt == FIRST_SAMPLE))
    else $error("falling edge did not start detection");

  a_reject_window: assert property (
    prev_start && (state == ST_IDLE) |-> $past(tick)
      && (prev_num == $past(first_vote) + 5'h02))
    else $error("start dropped outside its vote window");

  a_noise_reject: assert property (
    start_reject |=> (state == ST_IDLE) && !frame_valid)
    else $error("noisy start was not rejected");

  a_state_range: assert property (
    (state != ST_IDLE) |-> (cnt >= FIRST_SAMPLE) && (cnt <= spb))
    else $error("sample state out of range");

  a_stop_error: assert property (
    frame_done |=> frame.stop_bit_error_flag == !$past(vote_bit))
    else $error("stop bit error flag wrong");

  a_early_restart: assert property (
    frame_done |=> (state == ST_IDLE))
    else $error("receiver not ready after stop vote");

  a_filter_drop: assert property (
    frame_done && cfg.address_filter_enable && !frame_type
      |=> !frame_valid)
    else $error("data frame passed the address filter");

  a_accept_data: assert property (
    frame_done && (!cfg.address_filter_enable || frame_type)
      |=> frame_valid ##1 !frame_valid)
    else $error("accepted frame not handed off once");

  a_ninth_type: assert property (
    frame_valid && cfg.address_filter_enable
      && (cfg.data_bits == DATA_BITS_MAX) |-> frame.ninth_received_bit)
    else $error("nine bit frame type not from ninth bit");

  a_data_vote: assert property (
    (state == ST_BITS) && at_last_vote && (bit_idx < cfg.data_bits)
      |=> shift[$past(bit_idx)] == $past(vote_bit))
    else $error("data bit not taken from centre vote");

  a_start_accept: assert property (
    (state == ST_START) && at_last_vote && !vote_bit
      |=> (state == ST_BITS) && (bit_idx == 4'h0) && (shift == '0))
    else $error("valid start did not begin data recovery");

  a_stop_type: assert property (
    frame_done && (cfg.data_bits != DATA_BITS_MAX)
      |=> frame.address_frame == !frame.stop_bit_error_flag)
    else $error("short frame type not taken from stop bit");

  c_frame_ok: cover property (frame_valid && !frame.stop_bit_error_flag);
  c_noise: cover property (start_reject);
  c_stop_err: cover property (frame_valid && frame.stop_bit_error_flag);
  c_filtered: cover property (frame_done && cfg.address_filter_enable
    && !frame_type);
  c_address_kept: cover property (frame_valid && frame.address_frame
    && cfg.address_filter_enable);

endmodule : uart_rx_recovery
`default_nettype wire

// ==== tb/serial_tx_model.sv ====
// Purpose: remote serial transmitter on the shared receive line
// Assumes: line idles high through a pull-up; LSB first, one start bit
// Notes: bit time is exact, so the rate error sits well inside budget
`timescale 1ns/10ps
`default_nettype none
module serial_tx_model (
  input wire logic clk,
  output logic line
);
  // ----------------------------------------------------------------
  // line driver
  // ----------------------------------------------------------------
  initial line = 1'b1; // idle level of the pulled-up line

  // drive a level for n clocks, changing only at falling edges
  task automatic hold(input logic v, input int n);
    line = v;
    repeat (n) @(negedge clk);
  endtask : hold

  // start, nb bits LSB first, stop level held for ns samples
  task automatic send(input logic [11:0] bits, input int nb,
    input logic stop, input int spb, input int tk, input int ns);
    hold(1'b0, spb * tk);
    for (int i = 0; i < nb; i++) begin
      hold(bits[i], spb * tk);
    end
    hold(stop, ns * tk);
    // back to idle only after a low stop, so the line is set once per step
    if (!stop) begin
      line = 1'b1;
    end
  endtask : send
endmodule : serial_tx_model
`default_nettype wire

// ==== tb/uart_async_rx_recovery_mpcm_tb.sv ====
// Purpose: self-checking bench of the receive recovery block
// Assumes: partner drives the line; config changes only between frames
// Notes: xorshift stimulus with fixed seed plus corner cases
`timescale 1ns/10ps
`default_nettype none
module uart_async_rx_recovery_mpcm_tb;
  import uart_rx_pkg::*;
  logic clk;
  logic arst_n = 1'b0;
  logic serial_in_pin;
  logic [11:0] baud_divisor = 12'h000;
  rx_cfg_t cfg = '0;
  rx_frame_t frame;
  rx_frame_t seen;
  logic frame_valid;
  logic rx_busy;
  logic [31:0] rng = 32'h4fc6a6e1;
  logic [31:0] r;
  int errors = 0;
  int compares = 0;
  int nvalid = 0;
  int tk = 1;
  int spb = 16;
  int fv = 8;
  int n0;

  uart_rx_recovery #(.DIV_W(12)) i_uart_rx_recovery (.clk(clk),
    .arst_n(arst_n), .serial_in_pin(serial_in_pin),
    .baud_divisor(baud_divisor), .cfg(cfg), .frame(frame),
    .frame_valid(frame_valid), .rx_busy(rx_busy));
  serial_tx_model i_serial_tx_model (.clk(clk), .line(serial_in_pin));

  // ----------------------------------------------------------------
  // clock, monitor, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // count accepted frames and keep the last one
  always @(posedge clk) begin
    if (frame_valid === 1'b1) begin
      nvalid++;
      seen = frame;
    end
  end

  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    test_done();
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  task automatic check(input string what, input logic [8:0] got,
    input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic setup(input logic ds, input logic [3:0] nd,
    input logic par, input logic filt, input logic [1:0] dv);
    cfg = '{ds, nd, par, filt};
    baud_divisor = {10'h000, dv};
    tk = int'(dv) + 1;
    spb = ds ? int'(SAMPLES_DOUBLE) : int'(SAMPLES_NORMAL);
    fv = ds ? int'(FIRST_VOTE_DOUBLE) : int'(FIRST_VOTE_NORMAL);
    // old divisor may still be counting down; let ticks reach the new rate
    repeat (8) @(negedge clk);
  endtask : setup

  // send one frame and compare what was accepted since base
  task automatic xfer(input logic [8:0] d, input logic stop, input int ns,
    input int base);
    logic [8:0] m;
    logic [11:0] bits;
    logic typ;
    m = 9'h1ff >> (9 - int'(cfg.data_bits));
    bits = {3'h0, d & m};
    bits[cfg.data_bits] = ^d;
    typ = (cfg.data_bits == DATA_BITS_MAX) ? d[8] : stop;
    i_serial_tx_model.send(bits, int'(cfg.data_bits) +
      int'(cfg.parity_enable), stop, spb, tk, ns);
    repeat (4 * tk + 4) @(negedge clk);
    check("count", 9'(nvalid - base),
      9'(!cfg.address_filter_enable | typ));
    if (nvalid != base) begin
      check("data", seen.data & m, d & m);
      check("stop_flag", 9'(seen.stop_bit_error_flag), 9'(!stop));
      check("address", 9'(seen.address_frame), 9'(typ));
      if (cfg.parity_enable) begin
        check("parity", 9'(seen.parity_bit), 9'(^d));
      end
      if (cfg.data_bits == DATA_BITS_MAX) begin
        check("ninth", 9'(seen.ninth_received_bit), 9'(d[8]));
      end
    end
    check("busy", 9'(rx_busy), 9'h000);
  endtask : xfer

  // low pulse of n samples, then idle past a whole frame
  task automatic glitch(input int n, input logic ok);
    n0 = nvalid;
    i_serial_tx_model.hold(1'b0, n * tk);
    i_serial_tx_model.hold(1'b1, 12 * spb * tk);
    check("glitch_count", 9'(nvalid - n0), 9'(ok));
    check("glitch_busy", 9'(rx_busy), 9'h000);
    if (ok) begin
      check("glitch_data", seen.data, 9'h0ff);
    end
  endtask : glitch

  task automatic test_done();
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk);
    check("reset_valid", 9'(frame_valid), 9'h000);
    check("reset_data", frame.data, 9'h000);
    check("reset_busy", 9'(rx_busy), 9'h000);
    arst_n = 1'b1;
    repeat (20) @(negedge clk);
    // random formats, modes and rates, mostly good stop bits
    for (int i = 0; i < 30; i++) begin
      r = xs();
      setup(r[0], 4'(5 + r[3:1] % 5), r[4], 1'b0, r[6:5]);
      xfer(r[16:8], r[21:20] != 2'b00, spb, nvalid);
    end
    // start qualification boundary in both modes
    for (int k = 0; k < 2; k++) begin
      setup(k[0], 4'h8, 1'b0, 1'b0, 2'(xs()));
      glitch(fv, 1'b0);
      glitch(fv + 1, 1'b1);
    end
    // next start right after the stop vote samples
    for (int k = 0; k < 2; k++) begin
      setup(k[0], 4'h8, 1'b0, 1'b0, 2'h1);
      n0 = nvalid;
      i_serial_tx_model.send(12'h0a5, 8, 1'b1, spb, tk, fv + 2);
      xfer(9'h05a, 1'b1, spb, n0 + 1);
    end
    // address filter: data frames dropped, address frames kept
    for (int nd = 5; nd < 10; nd++) begin
      for (int t = 0; t < 2; t++) begin
        r = xs();
        setup(r[0], 4'(nd), r[1], 1'b1, r[3:2]);
        xfer({t[0], r[15:8]}, (nd == 9) | t[0], spb, nvalid);
      end
    end
    setup(1'b0, 4'h9, 1'b0, 1'b0, 2'h2);
    xfer(9'h033, 1'b1, spb, nvalid);
    test_done();
  end
endmodule : uart_async_rx_recovery_mpcm_tb
`default_nettype wire
